// *** rtl/v24os_consts.vh ***
// Operation
// RL1: Sample incoming data line at fixed 64 kHz into a 64 kbit/s timeslot.
// RL2: Attached equipment keeps over-sampled data rate at or below 19.2 kbit/s.
// RL3: In over-sampling mode ignore the DTE clock and drive no DCE clock.
// RL4: CTS source local RTS: CTS follows own RTS input, link status ignored.
// RL5: CTS source permanent: CTS held on always, never dropped on link failure.
// RL6: CTS behaviour unchanged whether or not loopback is active.
// RL7: Received data captured on selected edge of external transmit clock, falling default.
// RL8: Loopback returns port data to the customer; disabled by default.
// RL9: Four independently configured ports, each with own CTS, edge and loopback settings.
// RL10: Rate setting equal to the over-sampling code selects over-sampling mode.
// RL11: Over-sampled timeslot routable to an E1 or T1 trunk besides radio.
// RL12: Port always acts as DCE: drives CTS, receives RTS.
// RL13: Each sample maps to one timeslot bit; received bits replayed at same rate.
`ifndef V24OS_CONSTS_VH
`define V24OS_CONSTS_VH

`define V24OS_PORTS 4
`define V24OS_RATE_W 4
`define V24OS_RATE_OVS 4'hf
`define V24OS_CLK_HZ 25000000
`define V24OS_SAMPLE_HZ 64000
`define V24OS_ACC_W 25
`define V24OS_MAX_BAUD 19200

`define V24OS_CTS_LOCAL 1'h0
`define V24OS_CTS_PERM 1'h1
`define V24OS_EDGE_FALL 1'h0
`define V24OS_EDGE_RISE 1'h1
`define V24OS_ROUTE_RADIO 1'h0
`define V24OS_ROUTE_TRUNK 1'h1

`define V24OS_RST_MARK 1'h1
`define V24OS_RST_CTS 1'h0
`define V24OS_RST_CLK 1'h0
`define V24OS_RST_SYNC 3'h7

`endif

// *** rtl/v24os_tick.v ***
`timescale 1ns/10ps
`default_nettype none
`include "v24os_consts.vh"
module v24os_tick #(
  parameter integer CLK_HZ = `V24OS_CLK_HZ,
  parameter integer TICK_HZ = `V24OS_SAMPLE_HZ
) (
  input wire clk,
  input wire reset,
  output wire tick
);
  localparam [`V24OS_ACC_W-1:0] STEP = TICK_HZ[`V24OS_ACC_W-1:0];
  localparam [`V24OS_ACC_W-1:0] WRAP = CLK_HZ[`V24OS_ACC_W-1:0];
  reg [`V24OS_ACC_W-1:0] acc_q;
  reg [`V24OS_ACC_W-1:0] acc_d;
  reg tick_q;
  reg tick_d;
  wire [`V24OS_ACC_W:0] sum = {1'b0, acc_q} + {1'b0, STEP};

  ////////////////////////////////////////////////////////////////////////
  // Fractional accumulator gives an exact average 64 kHz enable
  always @* begin
    if (sum >= {1'b0, WRAP}) begin // [RL1]
      acc_d = sum[`V24OS_ACC_W-1:0] - WRAP;
      tick_d = 1'b1;
    end else begin
      acc_d = sum[`V24OS_ACC_W-1:0];
      tick_d = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      acc_q <= {`V24OS_ACC_W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// *** rtl/v24os_port.v ***
`timescale 1ns/10ps
`default_nettype none
`include "v24os_consts.vh"
module v24os_port #(
  parameter integer PORTS = `V24OS_PORTS,
  parameter integer CLK_HZ = `V24OS_CLK_HZ,
  parameter integer SAMPLE_HZ = `V24OS_SAMPLE_HZ
) (
  input wire clk,
  input wire reset,
  // Customer-side pins, asynchronous
  input wire [PORTS-1:0] txdPin,
  input wire [PORTS-1:0] rtsPin,
  input wire [PORTS-1:0] ext_tx_clock_in,
  output wire [PORTS-1:0] rxdPin,
  output wire [PORTS-1:0] ctsPin,
  output wire [PORTS-1:0] dceClkOut,
  // Per-port configuration
  input wire [PORTS*`V24OS_RATE_W-1:0] oversample_rate_code,
  input wire [PORTS-1:0] ctsSource,
  input wire [PORTS-1:0] captureEdge,
  input wire [PORTS-1:0] loopbackEn,
  input wire [PORTS-1:0] routeSel,
  // Timeslot side
  input wire [PORTS-1:0] radioRxBit,
  input wire [PORTS-1:0] trunkRxBit,
  output wire [PORTS-1:0] radioTxBit,
  output wire [PORTS-1:0] trunkTxBit,
  output wire sampleValid,
  // Status
  output wire [PORTS-1:0] overSampleActive,
  output wire [PORTS-1:0] capturedBit
);

  ////////////////////////////////////////////////////////////////////////
  // Shared sample-rate enable
  wire sampleTick;
  reg sampleValid_q;

  v24os_tick #(
    .CLK_HZ(CLK_HZ),
    .TICK_HZ(SAMPLE_HZ)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .tick(sampleTick)
  );

  always @(posedge clk) begin
    if (reset) begin
      sampleValid_q <= 1'b0;
    end else begin
      sampleValid_q <= sampleTick; // [RL1]
    end
  end

  assign sampleValid = sampleValid_q;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function isOverSample;
    input [`V24OS_RATE_W-1:0] code;
    begin
      isOverSample = (code == `V24OS_RATE_OVS);
    end
  endfunction

  function edgeSeen;
    input sel;
    input prev;
    input cur;
    begin
      if (sel == `V24OS_EDGE_RISE) begin
        edgeSeen = ~prev & cur;
      end else begin
        edgeSeen = prev & ~cur;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Per-port logic, each port from its own settings
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port // [RL9]
      reg [2:0] txdSync_q;
      reg [2:0] rtsSync_q;
      reg [2:0] clkSync_q;
      reg rxd_q;
      reg cts_q;
      reg dceClk_q;
      reg radioTx_q;
      reg trunkTx_q;
      reg ovs_q;
      reg cap_q;
      reg rxBit_d;
      wire ovsMode;

      assign ovsMode = isOverSample(
        oversample_rate_code[p*`V24OS_RATE_W +: `V24OS_RATE_W]); // [RL10]

      // Two flops before use; third stage only feeds edge detection
      always @(posedge clk) begin
        if (reset) begin
          txdSync_q <= `V24OS_RST_SYNC;
          rtsSync_q <= 3'h0;
          clkSync_q <= 3'h0;
        end else begin
          txdSync_q <= {txdSync_q[1:0], txdPin[p]};
          rtsSync_q <= {rtsSync_q[1:0], rtsPin[p]};
          clkSync_q <= {clkSync_q[1:0], ext_tx_clock_in[p]};
        end
      end

      // Received timeslot bit from the selected path
      always @* begin
        if (routeSel[p] == `V24OS_ROUTE_TRUNK) begin
          rxBit_d = trunkRxBit[p]; // [RL11]
        end else begin
          rxBit_d = radioRxBit[p];
        end
      end

      always @(posedge clk) begin
        if (reset) begin
          rxd_q <= `V24OS_RST_MARK;
          cts_q <= `V24OS_RST_CTS;
          dceClk_q <= `V24OS_RST_CLK;
          radioTx_q <= `V24OS_RST_MARK;
          trunkTx_q <= `V24OS_RST_MARK;
          ovs_q <= 1'b0;
          cap_q <= `V24OS_RST_MARK;
        end else begin
          ovs_q <= ovsMode;
          // DCE role: CTS out, RTS in, no loopback term
          if (ctsSource[p] == `V24OS_CTS_PERM) begin
            cts_q <= 1'b1; // [RL5] [RL12] [RL6]
          end else begin
            cts_q <= rtsSync_q[1]; // [RL4] [RL12] [RL6]
          end
          // No clock output in over-sampling mode
          dceClk_q <= `V24OS_RST_CLK; // [RL3]
          // Clock-edge capture only outside over-sampling mode
          if (!ovsMode && edgeSeen(captureEdge[p], clkSync_q[2], clkSync_q[1])) begin
            cap_q <= txdSync_q[1]; // [RL7] [RL3]
          end
          if (ovsMode) begin
            if (sampleTick) begin
              // One sample per timeslot bit, on the chosen path
              if (routeSel[p] == `V24OS_ROUTE_TRUNK) begin
                trunkTx_q <= txdSync_q[1]; // [RL1] [RL13] [RL11]
                radioTx_q <= `V24OS_RST_MARK;
              end else begin
                radioTx_q <= txdSync_q[1]; // [RL1] [RL13]
                trunkTx_q <= `V24OS_RST_MARK;
              end
              if (loopbackEn[p]) begin
                rxd_q <= txdSync_q[1]; // [RL8]
              end else begin
                rxd_q <= rxBit_d; // [RL13]
              end
            end
          end else begin
            radioTx_q <= `V24OS_RST_MARK;
            trunkTx_q <= `V24OS_RST_MARK;
            rxd_q <= `V24OS_RST_MARK;
          end
        end
      end

      assign rxdPin[p] = rxd_q;
      assign ctsPin[p] = cts_q;
      assign dceClkOut[p] = dceClk_q;
      assign radioTxBit[p] = radioTx_q;
      assign trunkTxBit[p] = trunkTx_q;
      assign overSampleActive[p] = ovs_q;
      assign capturedBit[p] = cap_q;
    end
  endgenerate

endmodule
`default_nettype wire

// *** sim/v24os_port_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module v24os_port_monitor #(parameter integer PORTS = 4) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [PORTS-1:0] txdPin,
  input wire logic [PORTS-1:0] rtsPin,
  input wire logic [PORTS-1:0] rxdPin,
  input wire logic [PORTS-1:0] ctsPin,
  input wire logic [PORTS-1:0] dceClkOut,
  input wire logic [PORTS-1:0] ctsSource,
  input wire logic [PORTS-1:0] loopbackEn,
  input wire logic [PORTS-1:0] routeSel,
  input wire logic [PORTS-1:0] radioRxBit,
  input wire logic [PORTS-1:0] radioTxBit,
  input wire logic [PORTS-1:0] trunkTxBit,
  input wire logic sampleValid,
  input wire logic [PORTS-1:0] overSampleActive
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence quiet_then_tick;
    !sampleValid[*8] ##[16:18] sampleValid;
  endsequence
  a_dce_clock_off: assert property (dceClkOut == '0)
    else $error("dce clock driven");
  a_cts_local: assert property ((!reset)[*4] |->
    ((ctsPin ^ $past(rtsPin, 3)) & ~ctsSource & ~$past(ctsSource)) == '0)
    else $error("cts not following rts");
  a_cts_perm: assert property (!$past(reset) |-> ($past(ctsSource) & ~ctsPin) == '0)
    else $error("cts dropped");
  a_sample_rate: assert property (sampleValid |=> quiet_then_tick)
    else $error("sample spacing");
  a_tx_hold: assert property (!sampleValid && &overSampleActive &&
    $stable(overSampleActive) && $stable(routeSel) |-> $stable(radioTxBit) && $stable(rxdPin))
    else $error("timeslot bit moved");
  a_tx_sample: assert property (sampleValid && &overSampleActive |->
    radioTxBit == ($past(txdPin, 3) | $past(routeSel)) &&
    trunkTxBit == ($past(txdPin, 3) | ~$past(routeSel)))
    else $error("tx bit wrong");
  a_rxd_replay: assert property (sampleValid && &overSampleActive && $past(routeSel) == '0 |->
    rxdPin == ($past(loopbackEn) & $past(txdPin, 3) | ~$past(loopbackEn) & $past(radioRxBit)))
    else $error("rxd wrong");
  a_mode_refuse: assert property (!$past(reset) |->
    (~overSampleActive & ~(radioTxBit & trunkTxBit & rxdPin)) == '0)
    else $error("idle port not marking");
endmodule
`default_nettype wire

// *** sim/v24os_dte.sv ***
`timescale 1ns/10ps
`default_nettype none
module v24os_dte (
  input wire logic clk,
  input wire logic send,
  input wire logic clkRun,
  input wire logic [3:0] rtsReq,
  output wire logic [3:0] txdPin,
  output wire logic [3:0] rtsPin,
  output wire logic [3:0] extClk
);
  logic [11:0] cnt_q = 12'h0;
  always @(posedge clk) begin
    cnt_q <= cnt_q + 12'h1;
  end
  // Slow bit time against the sample rate, mark when idle
  // Clocked data moves between clock edges: ports 1 and 3 low at falling, high at rising; ports 0 and 2 the reverse
  assign txdPin = !send ? 4'hf :
    clkRun ? {4{cnt_q[3] ^ cnt_q[2]}} ^ 4'h5 : {4{cnt_q[8]}} ^ 4'h5;
  assign rtsPin = rtsReq;
  assign extClk = clkRun ? {4{cnt_q[3]}} : 4'h0; // Runs only when asked
endmodule
`default_nettype wire

// *** sim/test_v24_oversampling_serial_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_v24_oversampling_serial_port;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic send = 1'b0;
  logic clkRun = 1'b0;
  logic [3:0] captureEdge = 4'h0;
  wire [3:0] capBit;
  logic [3:0] rtsReq = 4'h0, ctsSource = 4'h0, loopbackEn = 4'h0;
  logic [3:0] routeSel = 4'h0, radioRxBit = 4'h0, trunkRxBit = 4'h0;
  logic [15:0] code = 16'hffff;
  wire [3:0] txdPin, rtsPin, extClk, rxdPin, ctsPin, dceClk, radioTx, trunkTx, ovs;
  wire sampleValid;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  // Rows: ctsSource, rts, loopback, expected cts
  logic [15:0] rows [4] = '{16'h0505, 16'h0afa, 16'hf00f, 16'h3457};
  v24os_dte v24os_dte_i (.clk(clk), .send(send), .clkRun(clkRun), .rtsReq(rtsReq),
    .txdPin(txdPin),
    .rtsPin(rtsPin), .extClk(extClk));
  v24os_port #(.SAMPLE_HZ(1000000)) v24os_port_i (.clk(clk), .reset(reset),
    .txdPin(txdPin), .rtsPin(rtsPin), .ext_tx_clock_in(extClk), .rxdPin(rxdPin),
    .ctsPin(ctsPin), .dceClkOut(dceClk), .oversample_rate_code(code),
    .ctsSource(ctsSource), .captureEdge(captureEdge), .loopbackEn(loopbackEn),
    .routeSel(routeSel), .radioRxBit(radioRxBit), .trunkRxBit(trunkRxBit),
    .radioTxBit(radioTx), .trunkTxBit(trunkTx), .sampleValid(sampleValid),
    .overSampleActive(ovs), .capturedBit(capBit));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk iff sampleValid);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    chk(rxdPin & ~ctsPin & ~dceClk & ~ovs, 4'hf);
    reset <= 1'b0;
    foreach (rows[i]) begin
      {ctsSource, rtsReq, loopbackEn} <= rows[i][15:4];
      repeat (5) @(posedge clk);
      chk(ctsPin, rows[i][3:0]);
    end
    send <= 1'b1;
    loopbackEn <= 4'h0;
    routeSel <= 4'h3;
    trunkRxBit <= 4'h2;
    radioRxBit <= 4'h4;
    tick();
    tick();
    chk(rxdPin, 4'h6);
    send <= 1'b0;
    routeSel <= 4'h0;
    radioRxBit <= 4'h0;
    loopbackEn <= 4'hf;
    tick();
    tick();
    chk(rxdPin, 4'hf);
    code <= 16'hf3ff;
    repeat (3) @(posedge clk);
    chk(ovs, 4'hb);
    tick();
    code <= 16'h0000;
    send <= 1'b1;
    clkRun <= 1'b1;
    captureEdge <= 4'h3;
    repeat (48) @(posedge clk);
    chk(capBit, 4'h6);
    captureEdge <= 4'h0;
    repeat (48) @(posedge clk);
    chk(capBit, 4'h5);
    code <= 16'hffff;
    send <= 1'b0;
    repeat (48) @(posedge clk);
    chk(capBit, 4'h5);
    chk(dceClk, 4'h0);
    final_report();
  end
endmodule
bind v24os_port v24os_port_monitor #(.PORTS(PORTS)) v24os_port_monitor_i (.clk, .reset,
  .txdPin, .rtsPin, .rxdPin, .ctsPin, .dceClkOut, .ctsSource, .loopbackEn, .routeSel,
  .radioRxBit, .radioTxBit, .trunkTxBit, .sampleValid, .overSampleActive);
`default_nettype wire
